/* File: hw/pin_select_pkg.sv */
// package for the remappable input select bank: register map, field layout,
// reset values, routing table and the carrier types shared by the design files.
// assumes a 32-bit classic wishbone register bus with byte addresses.
package pin_select_pkg;

  localparam int NUM_SEL_REGS = 9;
  localparam int NUM_ROUTED = 16;
  localparam int FIELD_W = 6;
  localparam int REG_W = 16;
  localparam int ADR_W = 8;

  // byte offsets of the selection registers, one aligned word each
  localparam logic [ADR_W-1:0] CAPTURE3_4_OFFSET = 8'h00;
  localparam logic [ADR_W-1:0] CAPTURE5_6_OFFSET = 8'h04;
  localparam logic [ADR_W-1:0] CAPTURE7_8_OFFSET = 8'h08;
  localparam logic [ADR_W-1:0] COMPARE_FAULT_OFFSET = 8'h0c;
  localparam logic [ADR_W-1:0] CAPTURE9_OFFSET = 8'h10;
  localparam logic [ADR_W-1:0] UART_C_RECEIVE_OFFSET = 8'h14;
  localparam logic [ADR_W-1:0] UART_A_OFFSET = 8'h18;
  localparam logic [ADR_W-1:0] UART_B_OFFSET = 8'h1c;
  localparam logic [ADR_W-1:0] SPI_A_OFFSET = 8'h20;
  // control and status words
  localparam logic [ADR_W-1:0] LOCK_OFFSET = 8'h24;
  localparam logic [ADR_W-1:0] KEY_OFFSET = 8'h28;
  localparam logic [ADR_W-1:0] ROUTE_STATUS_OFFSET = 8'h2c;

  localparam logic [ADR_W-1:0] SEL_OFFSET [NUM_SEL_REGS] = '{
    CAPTURE3_4_OFFSET, CAPTURE5_6_OFFSET, CAPTURE7_8_OFFSET, COMPARE_FAULT_OFFSET,
    CAPTURE9_OFFSET, UART_C_RECEIVE_OFFSET, UART_A_OFFSET, UART_B_OFFSET, SPI_A_OFFSET};

  // field positions inside a selection register
  localparam int LOW_FIELD_LSB = 0;
  localparam int HIGH_FIELD_LSB = 8;

  // implemented-bit masks: both fields, or upper field only
  localparam logic [REG_W-1:0] BOTH_FIELDS_MASK = 16'h3f3f;
  localparam logic [REG_W-1:0] HIGH_FIELD_MASK = 16'h3f00;
  localparam logic [REG_W-1:0] SEL_IMPL_MASK [NUM_SEL_REGS] = '{
    BOTH_FIELDS_MASK, BOTH_FIELDS_MASK, BOTH_FIELDS_MASK, BOTH_FIELDS_MASK,
    HIGH_FIELD_MASK, HIGH_FIELD_MASK, BOTH_FIELDS_MASK, BOTH_FIELDS_MASK, BOTH_FIELDS_MASK};

  // every implemented selection bit comes up as one
  localparam logic [REG_W-1:0] SEL_RESET_BITS = 16'hffff;

  // lock word and unlock keys
  localparam int LOCK_BIT = 0;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h46;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h57;

  // routing table: which register and which field feeds each peripheral input
  localparam int IN_REG [NUM_ROUTED] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 5, 6, 6, 7, 7, 8, 8};
  localparam int IN_LSB [NUM_ROUTED] = '{
    LOW_FIELD_LSB, HIGH_FIELD_LSB, LOW_FIELD_LSB, HIGH_FIELD_LSB,
    LOW_FIELD_LSB, HIGH_FIELD_LSB, LOW_FIELD_LSB, HIGH_FIELD_LSB,
    HIGH_FIELD_LSB, HIGH_FIELD_LSB, LOW_FIELD_LSB, HIGH_FIELD_LSB,
    LOW_FIELD_LSB, HIGH_FIELD_LSB, LOW_FIELD_LSB, HIGH_FIELD_LSB};

  // unlock sequencer states
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_FIRST = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_t;

  // one wishbone request as the slave sees it
  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
  } wb_req_t;

  // routed peripheral inputs; the last member is bit 0 of the routing vector
  typedef struct packed {
    logic spi_a_clock;
    logic spi_a_data_in;
    logic uart_b_clear_to_send;
    logic uart_b_receive;
    logic uart_a_clear_to_send;
    logic uart_a_receive;
    logic uart_c_receive;
    logic capture9;
    logic compare_fault_b;
    logic compare_fault_a;
    logic capture8;
    logic capture7;
    logic capture6;
    logic capture5;
    logic capture4;
    logic capture3;
  } periph_inputs_t;

endpackage

/* File: hw/pin_sync.sv */
// two-flop synchroniser bank for the remappable pins.
// assumes the pins are asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 64
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

/* File: hw/pin_route_mux.sv */
// one pin selector: picks the pin whose number equals a 6-bit code.
// assumes synchronised pin levels; codes past the last pin give a low level.
`timescale 1ns/1ps
`default_nettype none

module pin_route_mux #(
  parameter int NUM_PINS = 64
) (
  input wire logic [NUM_PINS-1:0] pins_i,
  input wire logic [pin_select_pkg::FIELD_W-1:0] code_i,
  output logic bit_o
);

  // out-of-range codes are treated as an unconnected input
  always_comb begin
    bit_o = 1'b0;
    if (int'(code_i) < NUM_PINS) begin
      bit_o = pins_i[code_i];
    end
  end

endmodule

`default_nettype wire

/* File: hw/remappable_input_select_bank.sv */
// remappable input select bank: wishbone register file of selection words,
// a lock with unlock key sequence, and the pin-to-peripheral routing.
// assumes a classic wishbone master on sys_clk_i and asynchronous pins.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: capture 3 and 4 from low/high fields
// R2: capture 5 and 6 from low/high fields
// R3: capture 7 and 8 from low/high fields
// R4: compare fault A low, fault B high
// R5: capture 9 from high field, low byte zero
// R6: uart C receive high field, low byte zero
// R7: uart A receive low, clear-to-send high
// R8: uart B receive low, clear-to-send high
// R9: spi A data low, clock high
// R10: selection bits read/write, reset to ones
// R11: unimplemented bits always read zero
// R12: writes to unimplemented bits are ignored
// R13: selection writes accepted only while unlocked
// R14: selecting a pin never enables a peripheral
// R15: analog pins never feed a selected input
module remappable_input_select_bank #(
  parameter int NUM_PINS = 64
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pin_select_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_PINS-1:0] remappable_pin_i,
  input wire logic [NUM_PINS-1:0] pin_analog_mode_i,
  output pin_select_pkg::periph_inputs_t periph_in_o,
  output logic mapping_lock_bit_o
);

  localparam int NREGS = pin_select_pkg::NUM_SEL_REGS;
  localparam int NROUTE = pin_select_pkg::NUM_ROUTED;
  localparam int RW = pin_select_pkg::REG_W;
  localparam int FW = pin_select_pkg::FIELD_W;

  pin_select_pkg::wb_req_t req;
  pin_select_pkg::key_state_t key_state;
  pin_select_pkg::key_state_t next_key_state;
  logic [RW-1:0] select_reg [NREGS];
  logic [NREGS-1:0] sel_hit;
  logic [RW-1:0] lane_mask;
  logic bus_access;
  logic bus_write;
  logic lock_hit;
  logic key_hit;
  logic status_hit;
  logic [31:0] next_rdata;
  logic [NUM_PINS-1:0] pins_sync;
  logic [NUM_PINS-1:0] pins_digital;
  logic [NROUTE-1:0] routed;

  // one-hot hit vector over the selection registers, used by write and read
  function automatic logic [NREGS-1:0] sel_hits(input logic [pin_select_pkg::ADR_W-1:0] adr);
    logic [NREGS-1:0] hits;
    hits = '0;
    for (int i = 0; i < NREGS; i++) begin
      hits[i] = (adr == pin_select_pkg::SEL_OFFSET[i]);
    end
    return hits;
  endfunction

  // bundle the bus request; an access is taken once, on the edge ack rises
  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i};
  assign bus_access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_write = bus_access && req.we;
  assign sel_hit = sel_hits(req.adr);
  assign lock_hit = (req.adr == pin_select_pkg::LOCK_OFFSET);
  assign key_hit = (req.adr == pin_select_pkg::KEY_OFFSET);
  assign status_hit = (req.adr == pin_select_pkg::ROUTE_STATUS_OFFSET);

  // byte enables over the 16-bit register image; upper lanes carry nothing
  assign lane_mask = {{8{req.sel[1]}}, {8{req.sel[0]}}};

  // ack every cycle-qualified access, mapped or not, one cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_access;
    end
  end

  // unlock sequencer: two key bytes back to back arm one write to the lock word;
  // any other write drops the sequence, so a stray store cannot unlock by chance
  always_comb begin
    next_key_state = key_state;
    if (bus_write) begin
      case (key_state)
        pin_select_pkg::KEY_IDLE: begin
          if (key_hit && req.sel[0] && req.dat[7:0] == pin_select_pkg::UNLOCK_KEY_FIRST) begin
            next_key_state = pin_select_pkg::KEY_FIRST;
          end
        end
        pin_select_pkg::KEY_FIRST: begin
          if (key_hit && req.sel[0] && req.dat[7:0] == pin_select_pkg::UNLOCK_KEY_SECOND) begin
            next_key_state = pin_select_pkg::KEY_ARMED;
          end else begin
            next_key_state = pin_select_pkg::KEY_IDLE;
          end
        end
        pin_select_pkg::KEY_ARMED: begin
          next_key_state = pin_select_pkg::KEY_IDLE;
        end
        default: begin
          next_key_state = pin_select_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      key_state <= pin_select_pkg::KEY_IDLE;
    end else begin
      key_state <= next_key_state;
    end
  end

  // the lock bit changes only on the write that follows the key sequence
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mapping_lock_bit_o <= pin_select_pkg::LOCK_RESET;
    end else if (bus_write && lock_hit && req.sel[0] && key_state == pin_select_pkg::KEY_ARMED) begin
      mapping_lock_bit_o <= req.dat[pin_select_pkg::LOCK_BIT];
    end
  end

  // selection registers: only implemented bits of enabled lanes are stored,
  // and nothing is stored while the mapping is locked
  for (genvar g = 0; g < NREGS; g++) begin : gen_sel_reg
    logic [RW-1:0] wmask;
    assign wmask = lane_mask & pin_select_pkg::SEL_IMPL_MASK[g]; // R12
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        select_reg[g] <= pin_select_pkg::SEL_RESET_BITS & pin_select_pkg::SEL_IMPL_MASK[g]; // R10
      end else if (bus_write && sel_hit[g] && !mapping_lock_bit_o) begin // R13
        select_reg[g] <= (select_reg[g] & ~wmask) | (req.dat[RW-1:0] & wmask); // R10 R12
      end
    end
  end

  // read mux; stored values hold zero in every unimplemented position,
  // so reserved bits and the upper half-word read as zero
  always_comb begin
    next_rdata = '0;
    for (int i = 0; i < NREGS; i++) begin
      if (sel_hit[i]) begin
        next_rdata[RW-1:0] = select_reg[i] & pin_select_pkg::SEL_IMPL_MASK[i]; // R11 R5 R6
      end
    end
    if (lock_hit) begin
      next_rdata[pin_select_pkg::LOCK_BIT] = mapping_lock_bit_o;
    end
    if (status_hit) begin
      next_rdata[NROUTE-1:0] = periph_in_o;
    end
  end

  // read data is loaded with ack and held at zero otherwise
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wb_dat_o <= '0;
    end else if (bus_access && !req.we) begin
      wb_dat_o <= next_rdata;
    end else begin
      wb_dat_o <= '0;
    end
  end

  // pins come from outside the clock domain
  pin_sync #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i(remappable_pin_i),
    .sync_o(pins_sync)
  );

  // an analog-configured pin reads low to every selected input; the digital
  // mode must be set elsewhere before routing it means anything
  assign pins_digital = pins_sync & ~pin_analog_mode_i; // R15

  // one selector per peripheral input, indexed by the routing table:
  // 0/1 capture 3/4, 2/3 capture 5/6, 4/5 capture 7/8, 6/7 faults A/B,
  // 8 capture 9, 9 uart C receive, 10/11 uart A, 12/13 uart B, 14/15 spi A
  for (genvar r = 0; r < NROUTE; r++) begin : gen_route
    logic [FW-1:0] code;
    assign code = select_reg[pin_select_pkg::IN_REG[r]][pin_select_pkg::IN_LSB[r] +: FW]; // R1 R2 R3 R4 R5 R6 R7 R8 R9
    pin_route_mux #(
      .NUM_PINS(NUM_PINS)
    ) u_mux (
      .pins_i(pins_digital),
      .code_i(code),
      .bit_o(routed[r])
    );
  end

  // routed levels are registered; this block drives data only and has no
  // enable path into any peripheral, which keeps its own configuration
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      periph_in_o <= '0;
    end else begin
      periph_in_o <= pin_select_pkg::periph_inputs_t'(routed); // R14
    end
  end

endmodule

`default_nettype wire

/* File: verification/pin_select_asserts.sv */
// port checker for the input select bank: bus handshake, read-back, lock and masking.
// assumes the one-cycle classic wishbone answer of the bank.
`timescale 1ns/1ps
`default_nettype none
module pin_select_asserts #(
  parameter int NUM_PINS = 64
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pin_select_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_PINS-1:0] pin_analog_mode_i,
  input wire pin_select_pkg::periph_inputs_t periph_in_o,
  input wire logic mapping_lock_bit_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // a request the slave takes: an ack cycle is never a new access
  logic req;
  assign req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("request left unanswered");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack with no request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  rsvd_bits_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) <= pin_select_pkg::SPI_A_OFFSET |-> (wb_dat_o & 32'hffffc0c0) == 32'h0)
    else $error("reserved bits read nonzero");
  low_byte_a: assert property (wb_ack_o && ($past(wb_adr_i) == 8'h10 || $past(wb_adr_i) == 8'h14)
    |-> wb_dat_o[7:0] == 8'h0) else $error("low byte read nonzero");
  lock_cause_a: assert property ($changed(mapping_lock_bit_o)
    |-> $past(req && wb_we_i && wb_adr_i == pin_select_pkg::LOCK_OFFSET)) else $error("lock moved");
  analog_mask_a: assert property (&($past(pin_analog_mode_i)) |-> periph_in_o == '0)
    else $error("analog pin reached an input");
endmodule
bind remappable_input_select_bank pin_select_asserts #(.NUM_PINS(NUM_PINS)) u_asserts (.sys_clk_i, .reset_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .pin_analog_mode_i, .periph_in_o,
  .mapping_lock_bit_o);
`default_nettype wire

/* File: verification/pin_far_end.sv */
// far-side model: remappable pin levels and their analog setting.
// assumes the bench sets levels; pins move just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module pin_far_end (
  input wire logic sys_clk_i,
  input wire logic [63:0] level_i,
  input wire logic [63:0] analog_i,
  output logic [63:0] pin_o = 64'h0,
  output logic [63:0] analog_o = 64'h0
);
  // one edge of lag, as a board pin trails the request that moves it
  always_ff @(posedge sys_clk_i) begin
    pin_o <= level_i;
    analog_o <= analog_i;
  end
endmodule
`default_nettype wire

/* File: verification/remappable_input_select_bank_tb_top.sv */
// testbench for the input select bank: reset values, lock, fields and routing.
// assumes the design, the far-side model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module remappable_input_select_bank_tb_top;
  localparam logic [63:0] PAT = 64'h01a5_005a;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, mapping_lock_bit_o;
  logic [63:0] level = 64'h0, analog = 64'h0, pins, pins_analog;
  pin_select_pkg::periph_inputs_t periph_in_o;
  int n_mismatch = 0, n_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  pin_far_end u_far (.sys_clk_i, .level_i(level), .analog_i(analog), .pin_o(pins), .analog_o(pins_analog));
  remappable_input_select_bank u_dut (.sys_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .remappable_pin_i(pins), .pin_analog_mode_i(pins_analog),
    .periph_in_o, .mapping_lock_bit_o);
  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; the request stands until ack is seen at an edge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int i;
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {adr, sel, dat};
    i = 0;
    do begin
      @(posedge sys_clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    // judge by the answer itself, so an ack on the last allowed edge is not a timeout
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic set_lock(input logic v);
    xfer(1'b1, pin_select_pkg::KEY_OFFSET, 4'h1, 32'h46);
    xfer(1'b1, pin_select_pkg::KEY_OFFSET, 4'h1, 32'h57);
    xfer(1'b1, pin_select_pkg::LOCK_OFFSET, 4'h1, {31'h0, v});
  endtask
  task automatic reset_values();
    for (int r = 0; r < 9; r++) begin
      xfer(1'b0, pin_select_pkg::SEL_OFFSET[r], 4'hf, 32'h0);
      check("reset value", rd, {16'h0, pin_select_pkg::SEL_IMPL_MASK[r]});
    end
  endtask
  // a locked bank ignores field writes and key-less lock writes
  task automatic lock_blocks();
    set_lock(1'b1);
    check("lock set", {31'h0, mapping_lock_bit_o}, 32'h1);
    xfer(1'b1, 8'h00, 4'h3, 32'h0505);
    xfer(1'b1, pin_select_pkg::LOCK_OFFSET, 4'h1, 32'h0);
    xfer(1'b0, 8'h00, 4'hf, 32'h0);
    check("locked write", rd, 32'h3f3f);
    check("lock kept", {31'h0, mapping_lock_bit_o}, 32'h1);
    set_lock(1'b0);
    check("lock clear", {31'h0, mapping_lock_bit_o}, 32'h0);
  endtask
  // codes r and r+16 with reserved bits set, one byte lane, then an unmapped word
  task automatic fields();
    for (int r = 0; r < 9; r++) begin
      xfer(1'b1, pin_select_pkg::SEL_OFFSET[r], 4'hf, {16'hffff, 2'b11, 6'(r + 16), 2'b11, 6'(r)});
      xfer(1'b0, pin_select_pkg::SEL_OFFSET[r], 4'hf, 32'h0);
      check("field write", rd, {16'h0, 2'b0, 6'(r + 16), 2'b0, 6'(r)} & pin_select_pkg::SEL_IMPL_MASK[r]);
    end
    xfer(1'b1, 8'h20, 4'h2, 32'h3f3f);
    xfer(1'b0, 8'h20, 4'hf, 32'h0);
    check("upper lane", rd, 32'h3f08);
    xfer(1'b1, 8'h20, 4'h3, 32'h1808);
    xfer(1'b1, 8'h3c, 4'hf, 32'hffff);
    xfer(1'b0, 8'h3c, 4'hf, 32'h0);
    check("unmapped read", rd, 32'h0);
  endtask
  // pattern, inverse, then all pins analog; each input follows its own field
  task automatic routing();
    logic [15:0] exp;
    for (int k = 0; k < 3; k++) begin
      level <= (k == 1) ? ~PAT : PAT;
      analog <= (k == 2) ? '1 : '0;
      repeat (5) @(posedge sys_clk_i);
      for (int j = 0; j < 16; j++) begin
        exp[j] = (k == 2) ? 1'b0 : level[pin_select_pkg::IN_REG[j] + pin_select_pkg::IN_LSB[j] * 2];
      end
      check("routed inputs", {16'h0, periph_in_o}, {16'h0, exp});
      xfer(1'b0, pin_select_pkg::ROUTE_STATUS_OFFSET, 4'hf, 32'h0);
      check("route status", rd, {16'h0, exp});
    end
    analog <= '0;
  endtask
  // reset in mid-run while locked and with written fields: all must come back
  task automatic reset_again();
    set_lock(1'b1);
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    check("lock after reset", {31'h0, mapping_lock_bit_o}, 32'h0);
    reset_values();
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    reset_values();
    lock_blocks();
    fields();
    routing();
    reset_again();
    conclude();
  end
endmodule
`default_nettype wire
